/* dv/crf_regfile_tb_top.sv */
`timescale 1ns/1ps
module crf_regfile_tb_top;
  import crf_pkg::*;
  // ****************************************
  // Signals
  // ****************************************
  logic          mclk_i = 1'b0, resetn_i = 1'b0;
  logic [7:0]    bus_addr_i = 8'h00, pfx_byte_i = 8'h00, io_imm_i = 8'h00;
  logic [15:0]   bus_wdata_i = 16'h0000, seg_data_i = 16'h0000;
  logic [15:0]   ip_value_i = 16'h0000, ea_off_i = 16'h0000;
  logic          bus_wr_i = 1'b0, bus_rd_i = 1'b0, seg_we_i = 1'b0;
  logic          str_step_i = 1'b0, str_wide_i = 1'b0, push_i = 1'b0, pop_i = 1'b0;
  logic          ip_load_i = 1'b0, ip_adv_i = 1'b0, pfx_valid_i = 1'b0;
  logic          instr_done_i = 1'b0, ea_ptr_i = 1'b0, io_direct_i = 1'b0;
  logic          ext_irq_i = 1'b0, nmi_i = 1'b0, ovf_trap_i = 1'b0;
  logic [1:0]    seg_sel_i = 2'h0;
  logic [2:0]    ip_len_i = 3'h0;
  crf_wr_t       ex_wr_i = '0;
  crf_alu_t      alu_i = '0;
  crf_flag_ctl_t flag_ctl_i = '0;
  logic [15:0]   bus_rdata_o, alu_result_o, io_addr_o, io_addr_hi_o;
  logic [19:0]   fetch_addr_o, opnd_addr_o, opnd_addr_hi_o, stack_addr_o;
  crf_flags_t    flags_o;
  logic          irq_take_o, nmi_take_o, ovf_int_o, step_int_o;
  int            fail_count = 0, n_compared = 0, cyc_count = 0, i, s;
  logic          rd_pend = 1'b0, alu_pend = 1'b0;
  logic [31:0]   lf = 32'h0001_3864;
  logic [15:0]   v[13], dv[4], sv[4], si, di, st, b;
  logic [8:0]    ef = 9'h000;
  logic [24:0]   ev;
  logic [15:0]   exp_q[$];
  logic [24:0]   alu_q[$];

  crf_regfile DUT (.*);

  always #5 mclk_i = ~mclk_i;

  // ****************************************
  // Helpers
  // ****************************************
  function logic [15:0] rnd();
    repeat (16) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[15:0];
  endfunction
  function logic [19:0] pa(input logic [15:0] sg, input logic [15:0] of);
    return {sg, 4'h0} + {4'h0, of};
  endfunction
  task tk();
    @(posedge mclk_i);
  endtask
  task chk(input logic [19:0] e, input logic [19:0] g, input string nm);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_of_test();
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [15:0] d);
    tk(); bus_addr_i <= a; bus_wdata_i <= d; bus_wr_i <= 1'b1;
    tk(); bus_wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    tk(); bus_addr_i <= a; bus_rd_i <= 1'b1;
    tk(); bus_rd_i <= 1'b0;
  endtask
  task exw(input logic w, input logic [2:0] sl, input logic [15:0] d);
    tk(); ex_wr_i <= '{1'b1, w, sl, d};
    tk(); ex_wr_i.we <= 1'b0;
  endtask
  task sgw(input logic [1:0] sl, input logic [15:0] d);
    tk(); seg_we_i <= 1'b1; seg_sel_i <= sl; seg_data_i <= d;
    tk(); seg_we_i <= 1'b0;
  endtask
  task fc(input logic [5:0] m);
    tk(); flag_ctl_i <= m;
    tk(); flag_ctl_i <= '0;
  endtask
  task alu(input crf_alu_op_t op, input logic w, input logic [15:0] a, input logic [15:0] bb);
    logic [16:0] sm;
    logic [15:0] r, x;
    int m;
    m = w ? 15 : 7;
    sm = (op == CRF_OP_ADD) ? (w ? a + bb : a[7:0] + bb[7:0]) :
         (op == CRF_OP_SUB) ? (w ? a - bb : a[7:0] - bb[7:0]) : 17'(a & bb);
    r = w ? sm[15:0] : {8'h00, sm[7:0]};
    x = a ^ bb ^ r;
    if (op == CRF_OP_ROL) begin
      r = w ? {a[14:0], a[15]} : {8'h00, a[6:0], a[7]};
      ef[0] = a[m];
    end else begin
      ef[0] = (op == CRF_OP_AND) ? 1'b0 : sm[m + 1];
      ef[1] = ~^r;
      ef[2] = (op == CRF_OP_AND) ? 1'b0 : x[4];
      ef[3] = (r == 16'h0000);
      ef[4] = r[m];
      ef[8] = (op == CRF_OP_ADD) ? (a[m] == bb[m] && r[m] != a[m]) :
              (op == CRF_OP_SUB) ? (a[m] != bb[m] && r[m] != a[m]) : 1'b0;
    end
    alu_q.push_back({ef, r});
    tk(); alu_i <= '{1'b1, w, op, a, bb};
    tk(); alu_i.valid <= 1'b0;
  endtask

  // ****************************************
  // Output monitor and timeout
  // ****************************************
  always @(posedge mclk_i) begin
    if (rd_pend) chk(20'(exp_q.pop_front()), 20'(bus_rdata_o), "bus_rdata_o");
    if (alu_pend) begin
      ev = alu_q.pop_front();
      chk(20'(ev[15:0]), 20'(alu_result_o), "alu_result_o");
      chk(20'(ev[24:16]), 20'(flags_o), "flags_o");
      chk(20'(ev[24] & ovf_trap_i), 20'(ovf_int_o), "ovf_int_o");
    end
    rd_pend <= bus_rd_i;
    alu_pend <= alu_i.valid;
    cyc_count++;
    if (cyc_count == 20000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (8) tk();
    resetn_i <= 1'b1;
    #1 chk(20'h00000, fetch_addr_o, "fetch_addr_o");
    for (i = 0; i < 13; i++) rd(8'(i * 4), 16'h0000);
    for (i = 0; i < 13; i++) begin
      v[i] = rnd();
      wr(8'(i * 4), v[i]);
    end
    wr(8'h34, 16'hFFFF);
    wr(8'h02, 16'hFFFF);
    for (i = 0; i < 13; i++) rd(8'(i * 4), (i == 12) ? v[i] & 16'h01FF : v[i]);
    rd(8'h34, 16'h0000);
    rd(8'h02, 16'h0000);
    for (i = 0; i < 4; i++) begin
      dv[i] = rnd();
      exw(1'b0, 3'(i), {8'h00, dv[i][7:0]});
      exw(1'b0, 3'(i + 4), {8'h00, dv[i][15:8]});
      rd(8'(i * 4), dv[i]);
    end
    for (s = 0; s < 4; s++) begin
      sv[s] = (s == 1) ? 16'hFFFF : rnd();
      sgw(2'(s), sv[s]);
    end
    tk(); ip_load_i <= 1'b1; ip_value_i <= 16'h0025;
    tk(); ip_load_i <= 1'b0;
    #1 chk(pa(sv[1], 16'h0025), fetch_addr_o, "fetch_addr_o");
    tk(); ip_adv_i <= 1'b1; ip_len_i <= 3'h6;
    tk(); ip_adv_i <= 1'b0;
    #1 chk(pa(sv[1], 16'h002B), fetch_addr_o, "fetch_addr_o");
    for (i = 0; i < 2; i++) begin
      tk(); ea_ptr_i <= i[0]; ea_off_i <= 16'hFFFF;
      #1 chk(pa(i ? sv[2] : sv[3], 16'hFFFF), opnd_addr_o, "opnd_addr_o");
      chk(pa(i ? sv[2] : sv[3], 16'hFFFF) + 20'h1, opnd_addr_hi_o, "opnd_addr_hi_o");
    end
    for (s = 0; s < 4; s++) begin
      tk(); pfx_valid_i <= 1'b1; pfx_byte_i <= 8'h26 | 8'(s << 3);
      tk(); pfx_valid_i <= 1'b0;
      #1 chk(pa(sv[s], 16'hFFFF), opnd_addr_o, "opnd_addr_o");
    end
    tk(); instr_done_i <= 1'b1;
    tk(); instr_done_i <= 1'b0;
    #1 chk(pa(sv[2], 16'hFFFF), opnd_addr_o, "opnd_addr_o");
    tk(); pfx_valid_i <= 1'b1; pfx_byte_i <= 8'h27;
    tk(); pfx_valid_i <= 1'b0;
    #1 chk(pa(sv[2], 16'hFFFF), opnd_addr_o, "opnd_addr_o");
    tk(); io_direct_i <= 1'b1; io_imm_i <= 8'hFF;
    #1 chk(20'h000FF, 20'(io_addr_o), "io_addr_o");
    chk(20'h00100, 20'(io_addr_hi_o), "io_addr_hi_o");
    tk(); io_direct_i <= 1'b0;
    #1 chk(20'(dv[2]), 20'(io_addr_o), "io_addr_o");
    exw(1'b1, 3'h4, 16'h0000);
    tk(); push_i <= 1'b1;
    #1 chk(pa(sv[2], 16'hFFFE), stack_addr_o, "stack_addr_o");
    tk(); push_i <= 1'b0;
    rd(8'h10, 16'hFFFE);
    tk(); pop_i <= 1'b1;
    #1 chk(pa(sv[2], 16'hFFFE), stack_addr_o, "stack_addr_o");
    tk(); pop_i <= 1'b0;
    rd(8'h10, 16'h0000);
    si = 16'h0001;
    di = 16'hFFFF;
    exw(1'b1, 3'h6, si);
    exw(1'b1, 3'h7, di);
    for (i = 0; i < 4; i++) begin
      fc(i[1] ? 6'h20 : 6'h10);
      tk(); str_step_i <= 1'b1; str_wide_i <= i[0];
      tk(); str_step_i <= 1'b0;
      st = i[0] ? 16'h0002 : 16'h0001;
      si = i[1] ? si - st : si + st;
      di = i[1] ? di - st : di + st;
      rd(8'h18, si);
      rd(8'h1C, di);
    end
    wr(8'h30, 16'h0000);
    ovf_trap_i <= 1'b1;
    alu(CRF_OP_ADD, 1'b1, 16'h7FFF, 16'h0001);
    alu(CRF_OP_ADD, 1'b0, 16'h12FF, 16'h0001);
    alu(CRF_OP_SUB, 1'b1, 16'h0000, 16'h0001);
    alu(CRF_OP_AND, 1'b1, 16'hF0F1, 16'h8F0F);
    alu(CRF_OP_ROL, 1'b1, 16'h8000, 16'h0001);
    for (i = 0; i < 40; i++) begin
      b = rnd();
      alu(crf_alu_op_t'(b[1:0]), b[2], rnd(), (b[1:0] == 2'h3) ? 16'h0001 : rnd());
    end
    ovf_trap_i <= 1'b0;
    ext_irq_i <= 1'b1;
    nmi_i <= 1'b1;
    for (i = 0; i < 2; i++) begin
      fc(i ? 6'h04 : 6'h08);
      #1 chk(20'(i == 0), 20'(irq_take_o), "irq_take_o");
      chk(20'h00001, 20'(nmi_take_o), "nmi_take_o");
    end
    for (i = 0; i < 2; i++) begin
      fc(i ? 6'h01 : 6'h02);
      tk(); instr_done_i <= 1'b1;
      tk(); instr_done_i <= 1'b0;
      #1 chk(20'(i == 0), 20'(step_int_o), "step_int_o");
      tk();
      #1 chk(20'h00000, 20'(step_int_o), "step_int_o");
    end
    repeat (3) tk();
    end_of_test();
  end
endmodule

/* rtl/crf_addr_gen.sv */
`timescale 1ns/1ps
`include "crf_defs.svh"

module crf_addr_gen (
  input  wire logic [15:0] seg_i,
  input  wire logic [15:0] off_i,
  output logic      [19:0] phys_o,
  output logic      [19:0] phys_hi_o
);

  // ****************************************
  // Segment base plus offset, 20-bit wrap
  // ****************************************
  // base on 16-byte boundary
  wire [20:0] sum = {1'b0, seg_i, `CRF_SEG_ZEROS} + {5'h00, off_i};

  assign phys_o    = sum[19:0];
  assign phys_hi_o = phys_o + 20'h00001;

endmodule

/* rtl/crf_defs.svh */
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// ****************************************
// Register bus offsets
// ****************************************
`define CRF_OFS_GPR    8'h00
`define CRF_OFS_SEG    8'h20
`define CRF_OFS_FLAGS  8'h30
`define CRF_OFS_END    8'h34
`define CRF_IDX_SEG    4'h8
`define CRF_IDX_FLAGS  4'hC

// ****************************************
// Reset values
// ****************************************
`define CRF_RST_WORD   16'h0000
`define CRF_RST_FLAGS  9'h000

// ****************************************
// Register and segment codes
// ****************************************
`define CRF_REG_DX     3'h2
`define CRF_REG_SP     3'h4
`define CRF_REG_SI     3'h6
`define CRF_REG_DI     3'h7
`define CRF_SEG_ES     2'h0
`define CRF_SEG_CS     2'h1
`define CRF_SEG_SS     2'h2
`define CRF_SEG_DS     2'h3

// ****************************************
// Prefix byte, stack and address forming
// ****************************************
`define CRF_PFX_MASK   8'hE7
`define CRF_PFX_MATCH  8'h26
`define CRF_PFX_SEG_LO 3
`define CRF_STACK_STEP 16'h0002
`define CRF_SEG_ZEROS  4'h0

`endif

/* rtl/crf_pkg.sv */
package crf_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    CRF_OP_ADD,
    CRF_OP_SUB,
    CRF_OP_AND,
    CRF_OP_ROL
  } crf_alu_op_t;

  typedef struct packed {
    logic        signed_overflow_flag;
    logic        string_direction_flag;
    logic        int_enable_flag;
    logic        single_step_flag;
    logic        negative_flag;
    logic        result_zero_flag;
    logic        nibble_carry_flag;
    logic        even_parity_flag;
    logic        carry_out_flag;
  } crf_flags_t;

  typedef struct packed {
    logic        we;
    logic        wide;
    logic [2:0]  sel;
    logic [15:0] data;
  } crf_wr_t;

  typedef struct packed {
    logic        valid;
    logic        wide;
    crf_alu_op_t op;
    logic [15:0] a;
    logic [15:0] b;
  } crf_alu_t;

  typedef struct packed {
    logic set_dir;
    logic clr_dir;
    logic set_int;
    logic clr_int;
    logic set_step;
    logic clr_step;
  } crf_flag_ctl_t;

endpackage

/* rtl/crf_regfile.sv */
// Overview of operation
// - One megabyte byte memory space plus separate 64K port space.
// - Word access uses low byte at address, high byte at next.
// - Segments start at multiples of 16 and span 64K bytes.
// - Physical address is segment shifted left four plus offset.
// - Four segment registers hold the upper 16 bits of segment bases.
// - Port addresses are flat, never relocated; byte or word sized.
// - Ports 0-255 by immediate address; any port via register.
// - Thirteen 16-bit registers, nine flags; instruction offset hidden.
// - Data registers work as words or byte halves; others words only.
// - Pointer and index registers join arithmetic like data registers.
// - Pointer offsets default to stack segment, index offsets to data.
// - Every fetch uses code segment with instruction offset.
// - A prefix byte selects the operand segment instead of default.
// - Nibble carry set on carry or borrow at low nibble.
// - Carry set on carry or borrow at top bit; rotates load it.
// - Overflow set on signed overflow; overflow trap instruction raises interrupt only while overflow is set.
// - Negative flag equals result top bit.
// - Parity flag set when result has even count of ones.
// - Zero flag set exactly when result is zero.
// - Direction flag set decrements string registers, clear increments.
// - Interrupt enable gates maskable external requests only.
// - Setting the step flag enters single-step mode.
// - In single-step mode an internal interrupt follows each instruction.
// - Push lowers stack pointer by 2 first; pop raises it after.
//
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "crf_defs.svh"

module crf_regfile (
  input  wire logic                   mclk_i,
  input  wire logic                   resetn_i,
  input  wire logic [7:0]             bus_addr_i,
  input  wire logic [15:0]            bus_wdata_i,
  input  wire logic                   bus_wr_i,
  input  wire logic                   bus_rd_i,
  output logic      [15:0]            bus_rdata_o,
  input  wire crf_pkg::crf_wr_t       ex_wr_i,
  input  wire logic                   seg_we_i,
  input  wire logic [1:0]             seg_sel_i,
  input  wire logic [15:0]            seg_data_i,
  input  wire crf_pkg::crf_alu_t      alu_i,
  output logic      [15:0]            alu_result_o,
  input  wire crf_pkg::crf_flag_ctl_t flag_ctl_i,
  input  wire logic                   str_step_i,
  input  wire logic                   str_wide_i,
  input  wire logic                   push_i,
  input  wire logic                   pop_i,
  input  wire logic                   ip_load_i,
  input  wire logic [15:0]            ip_value_i,
  input  wire logic                   ip_adv_i,
  input  wire logic [2:0]             ip_len_i,
  input  wire logic                   pfx_valid_i,
  input  wire logic [7:0]             pfx_byte_i,
  input  wire logic                   instr_done_i,
  input  wire logic [15:0]            ea_off_i,
  input  wire logic                   ea_ptr_i,
  input  wire logic                   io_direct_i,
  input  wire logic [7:0]             io_imm_i,
  input  wire logic                   ext_irq_i,
  input  wire logic                   nmi_i,
  input  wire logic                   ovf_trap_i,
  output logic      [19:0]            fetch_addr_o,
  output logic      [19:0]            opnd_addr_o,
  output logic      [19:0]            opnd_addr_hi_o,
  output logic      [19:0]            stack_addr_o,
  output logic      [15:0]            io_addr_o,
  output logic      [15:0]            io_addr_hi_o,
  output crf_pkg::crf_flags_t         flags_o,
  output logic                        irq_take_o,
  output logic                        nmi_take_o,
  output logic                        ovf_int_o,
  output logic                        step_int_o
);
  import crf_pkg::*;

  // ****************************************
  // State
  // ****************************************
  logic [15:0] gpr_r   [0:7];
  logic [15:0] gpr_nxt [0:7];
  logic [15:0] seg_r   [0:3];
  logic [15:0] seg_nxt [0:3];
  logic [15:0] ip_r;
  logic [15:0] ip_nxt;
  crf_flags_t  flags_r;
  crf_flags_t  flags_nxt;
  logic [15:0] rdata_r;
  logic [15:0] alu_res_r;
  logic        ovr_r;
  logic [1:0]  ovr_seg_r;
  logic        step_r;

  // ****************************************
  // Register bus decode
  // ****************************************
  wire       bus_map   = (bus_addr_i[1:0] == 2'h0) && (bus_addr_i < `CRF_OFS_END);
  wire [3:0] bus_idx   = bus_addr_i[5:2];
  wire       bus_wr_ok = bus_wr_i && bus_map;
  wire       flag_hit  = bus_wr_ok && (bus_idx == `CRF_IDX_FLAGS);
  wire [15:0] rd_mux   = !bus_map ? 16'h0000 :
                         (bus_idx < `CRF_IDX_SEG) ? gpr_r[bus_idx[2:0]] :
                         (bus_idx < `CRF_IDX_FLAGS) ? seg_r[bus_idx[1:0]] :
                         {7'h00, flags_r};

  // ****************************************
  // Implicit pointer steps
  // ****************************************
  // direction chooses step
  wire [15:0] str_size = str_wide_i ? 16'h0002 : 16'h0001;
  wire [15:0] str_dlt  = flags_r.string_direction_flag ? (16'h0000 - str_size) : str_size;
  wire [15:0] stk_dlt  = push_i ? (16'h0000 - `CRF_STACK_STEP) :
                         pop_i ? `CRF_STACK_STEP : 16'h0000;

  // ****************************************
  // General and segment registers
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_gpr
      localparam logic [2:0] CODE = 3'(g);
      wire        bus_hit = bus_wr_ok && (bus_idx == {1'b0, CODE});
      wire        ex_word = ex_wr_i.we && ex_wr_i.wide && (ex_wr_i.sel == CODE);
      // byte halves only on data registers
      wire        ex_lo   = (g < 4) && ex_wr_i.we && !ex_wr_i.wide && (ex_wr_i.sel == CODE);
      wire        ex_hi   = (g < 4) && ex_wr_i.we && !ex_wr_i.wide &&
                            (ex_wr_i.sel == (CODE | 3'h4));
      wire [15:0] dlt     = (CODE == `CRF_REG_SP) ? stk_dlt :
                            ((CODE == `CRF_REG_SI) || (CODE == `CRF_REG_DI)) &&
                            str_step_i ? str_dlt : 16'h0000;
      assign gpr_nxt[g] = bus_hit ? bus_wdata_i :
                          ex_word ? ex_wr_i.data :
                          ex_lo   ? {gpr_r[g][15:8], ex_wr_i.data[7:0]} :
                          ex_hi   ? {ex_wr_i.data[7:0], gpr_r[g][7:0]} :
                          gpr_r[g] + dlt;
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          gpr_r[g] <= `CRF_RST_WORD;
        end else begin
          gpr_r[g] <= gpr_nxt[g];
        end
      end
    end

    for (g = 0; g < 4; g++) begin : g_seg
      localparam logic [1:0] CODE = 2'(g);
      wire bus_hit = bus_wr_ok && (bus_idx == (`CRF_IDX_SEG | {2'h0, CODE}));
      assign seg_nxt[g] = bus_hit ? bus_wdata_i :
                          (seg_we_i && seg_sel_i == CODE) ? seg_data_i : seg_r[g];
      always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          seg_r[g] <= `CRF_RST_WORD;
        end else begin
          seg_r[g] <= seg_nxt[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // Instruction offset
  // ****************************************
  // only control transfer or advance
  assign ip_nxt = ip_load_i ? ip_value_i :
                  ip_adv_i ? ip_r + {13'h0000, ip_len_i} : ip_r;

  // ****************************************
  // Arithmetic status
  // ****************************************
  wire [15:0] am   = alu_i.wide ? alu_i.a : {8'h00, alu_i.a[7:0]};
  wire [15:0] bm   = alu_i.wide ? alu_i.b : {8'h00, alu_i.b[7:0]};
  wire        subt = (alu_i.op == CRF_OP_SUB);
  wire [16:0] full = subt ? ({1'b0, am} - {1'b0, bm}) : ({1'b0, am} + {1'b0, bm});
  wire        a_top = alu_i.wide ? am[15] : am[7];
  wire        b_top = alu_i.wide ? bm[15] : bm[7];
  wire [15:0] rot  = alu_i.wide ? {am[14:0], am[15]} : {8'h00, am[6:0], am[7]};
  wire [15:0] arith = alu_i.wide ? full[15:0] : {8'h00, full[7:0]};
  wire [15:0] res  = (alu_i.op == CRF_OP_AND) ? (am & bm) :
                     (alu_i.op == CRF_OP_ROL) ? rot : arith;
  wire        r_top = alu_i.wide ? res[15] : res[7];
  wire        is_ar = (alu_i.op == CRF_OP_ADD) || subt;
  // carry or borrow at top bit
  wire        cf_ar = alu_i.wide ? full[16] : full[8];
  wire        af_ar = am[4] ^ bm[4] ^ full[4];
  wire        of_ar = (subt ? (a_top != b_top) : (a_top == b_top)) && (r_top != a_top);

  always_comb begin
    flags_nxt = flags_r;
    if (alu_i.valid) begin
      flags_nxt.carry_out_flag = is_ar ? cf_ar : (alu_i.op == CRF_OP_ROL) ? a_top : 1'b0;
      if (alu_i.op != CRF_OP_ROL) begin
        flags_nxt.nibble_carry_flag    = is_ar & af_ar;
        flags_nxt.signed_overflow_flag = is_ar & of_ar;
        flags_nxt.negative_flag        = r_top;
        flags_nxt.even_parity_flag     = ~^res;
        flags_nxt.result_zero_flag     = (res == 16'h0000);
      end
    end
    if (flag_ctl_i.set_dir) flags_nxt.string_direction_flag = 1'b1;
    if (flag_ctl_i.clr_dir) flags_nxt.string_direction_flag = 1'b0;
    if (flag_ctl_i.set_int) flags_nxt.int_enable_flag = 1'b1;
    if (flag_ctl_i.clr_int) flags_nxt.int_enable_flag = 1'b0;
    if (flag_ctl_i.set_step) flags_nxt.single_step_flag = 1'b1;
    if (flag_ctl_i.clr_step) flags_nxt.single_step_flag = 1'b0;
    if (flag_hit) flags_nxt = crf_flags_t'(bus_wdata_i[8:0]);
  end

  // ****************************************
  // Segment prefix
  // ****************************************
  // prefix pattern distinct from opcodes
  wire pfx_hit = pfx_valid_i && ((pfx_byte_i & `CRF_PFX_MASK) == `CRF_PFX_MATCH);

  // ****************************************
  // Sequential state
  // ****************************************
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ip_r      <= `CRF_RST_WORD;
      flags_r   <= `CRF_RST_FLAGS;
      rdata_r   <= `CRF_RST_WORD;
      alu_res_r <= `CRF_RST_WORD;
      ovr_r     <= 1'b0;
      ovr_seg_r <= `CRF_SEG_DS;
      step_r    <= 1'b0;
    end else begin
      ip_r    <= ip_nxt;
      flags_r <= flags_nxt;
      if (bus_rd_i) begin
        rdata_r <= rd_mux;
      end
      if (alu_i.valid) begin
        alu_res_r <= res;
      end
      if (pfx_hit) begin
        ovr_r     <= 1'b1;
        ovr_seg_r <= pfx_byte_i[`CRF_PFX_SEG_LO +: 2];
      end else if (instr_done_i) begin
        ovr_r <= 1'b0;
      end
      step_r <= instr_done_i && flags_r.single_step_flag;
    end
  end

  // ****************************************
  // Address forming
  // ****************************************
  // pointer to stack, index to data
  wire [1:0]  opnd_seg = ovr_r ? ovr_seg_r : (ea_ptr_i ? `CRF_SEG_SS : `CRF_SEG_DS);
  wire [15:0] sp_w     = gpr_r[`CRF_REG_SP];
  wire [15:0] stk_off  = push_i ? (sp_w - `CRF_STACK_STEP) : sp_w;
  wire [15:0] ag_seg [0:2];
  wire [15:0] ag_off [0:2];
  wire [19:0] ag_lo  [0:2];
  wire [19:0] ag_hi  [0:2];

  assign ag_seg[0] = seg_r[`CRF_SEG_CS];
  assign ag_off[0] = ip_r;
  assign ag_seg[1] = seg_r[opnd_seg];
  assign ag_off[1] = ea_off_i;
  assign ag_seg[2] = seg_r[`CRF_SEG_SS];
  assign ag_off[2] = stk_off;

  generate
    for (g = 0; g < 3; g++) begin : g_ag
      crf_addr_gen u_ag (
        .seg_i     (ag_seg[g]),
        .off_i     (ag_off[g]),
        .phys_o    (ag_lo[g]),
        .phys_hi_o (ag_hi[g])
      );
    end
  endgenerate

  // ****************************************
  // Outputs
  // ****************************************
  // 20-bit memory, 16-bit ports
  assign fetch_addr_o   = ag_lo[0];
  assign opnd_addr_o    = ag_lo[1];
  assign opnd_addr_hi_o = ag_hi[1];
  assign stack_addr_o   = ag_lo[2];
  assign io_addr_o      = io_direct_i ? {8'h00, io_imm_i} : gpr_r[`CRF_REG_DX];
  assign io_addr_hi_o   = io_addr_o + 16'h0001;
  assign bus_rdata_o    = rdata_r;
  assign alu_result_o   = alu_res_r;
  assign flags_o        = flags_r;
  assign irq_take_o     = ext_irq_i && flags_r.int_enable_flag;
  assign nmi_take_o     = nmi_i;
  assign ovf_int_o      = ovf_trap_i && flags_r.signed_overflow_flag;
  assign step_int_o     = step_r;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);

  wire quiet = !bus_wr_i && !ex_wr_i.we;
  wire step_arm = instr_done_i && flags_r.single_step_flag;
  wire [19:0] fetch_ref = {seg_r[`CRF_SEG_CS], 4'h0} + {4'h0, ip_r};

  sequence s_prefix;
    pfx_hit && !ovr_r;
  endsequence
  sequence s_use;
    !pfx_valid_i && !instr_done_i;
  endsequence

  a_fetch_phys_form: assert property (fetch_addr_o == fetch_ref)
    else $error("fetch address not segment plus offset");
  a_seg_base_align: assert property ((ip_r == 16'h0000) |-> fetch_addr_o[3:0] == 4'h0)
    else $error("segment base not 16-aligned");
  a_push_sp_step: assert property (push_i && !pop_i && quiet
      |=> gpr_r[`CRF_REG_SP] == $past(gpr_r[`CRF_REG_SP]) - 16'h0002)
    else $error("push did not lower stack pointer by two");
  a_push_addr_new: assert property (push_i
      |-> stack_addr_o == {seg_r[`CRF_SEG_SS], 4'h0} + {4'h0, sp_w - `CRF_STACK_STEP})
    else $error("push address not at new top");
  a_str_dir_down: assert property (str_step_i && str_wide_i && flags_r.string_direction_flag
      && quiet |=> gpr_r[`CRF_REG_SI] == $past(gpr_r[`CRF_REG_SI]) - 16'h0002)
    else $error("string step ignored direction");
  a_zero_parity: assert property (alu_i.valid && alu_i.op != CRF_OP_ROL && !flag_hit
      |=> flags_r.result_zero_flag == (alu_result_o == 16'h0000)
          && flags_r.even_parity_flag == ~^alu_result_o)
    else $error("zero or parity flag wrong");
  a_sign_top: assert property (alu_i.valid && alu_i.wide && alu_i.op != CRF_OP_ROL && !flag_hit
      |=> flags_r.negative_flag == alu_result_o[15])
    else $error("sign flag not top bit");
  a_irq_gate_only: assert property (ext_irq_i && !flags_r.int_enable_flag |-> !irq_take_o
      && (nmi_take_o == nmi_i))
    else $error("maskable request passed while disabled");
  a_step_int_each: assert property (step_arm
      |=> step_int_o ##1 (step_int_o == $past(step_arm)))
    else $error("single step interrupt missing");
  a_prefix_select: assert property (s_prefix ##1 s_use
      |-> opnd_seg == $past(pfx_byte_i[4:3]))
    else $error("prefix did not select operand segment");
  a_ptr_default: assert property (!ovr_r && ea_ptr_i |-> opnd_seg == `CRF_SEG_SS)
    else $error("pointer offset not on stack segment");
  a_io_direct: assert property (io_direct_i |-> io_addr_o[15:8] == 8'h00
      && io_addr_o[7:0] == io_imm_i)
    else $error("direct port address wrong");

endmodule
